// *** inc/ddc_pkg.sv ***
// Constants and types for the DDR controller calibration and ordering block.
`default_nettype none
package ddc_pkg;
    localparam int          CLK_HZ          = 25_000_000;
    localparam logic [3:0]  GUARD_RESET     = 4'h0;
    localparam logic [3:0]  AGE_MAX         = 4'hF;
    localparam int          LANES           = 4;
    localparam int          CS_NUM          = 2;
    localparam int          ZQCS_NS         = 360;
    localparam int          ZQCL_NS         = 1_440;
    localparam int          ZQCS_CYC        = (ZQCS_NS * 25 + 999) / 1000;
    localparam int          ZQCL_CYC        = (ZQCL_NS * 25 + 999) / 1000;
    localparam int          PERIOD_DEF      = 100_000;
    localparam logic [31:0] ONE32           = 32'h0000_0001;
    localparam logic [7:0]  LANE_ZERO       = 8'h00;

    typedef enum logic [2:0]
    {
        ZQ_IDLE = 3'b000,
        ZQ_CMD0 = 3'b001,
        ZQ_WAIT0 = 3'b010,
        ZQ_CMD1 = 3'b011,
        ZQ_WAIT1 = 3'b100
    } ddc_zq_state_t;

    typedef struct packed
    {
        logic       valid;
        logic       long_cal;
        logic [1:0] cs_sel;
    } ddc_zq_cmd_t;

    typedef struct packed
    {
        logic [LANES-1:0]        err;
        logic [LANES*8-1:0]      result;
    } ddc_wl_stat_t;
endpackage
`default_nettype wire

// *** hw/ddc_core.sv ***
// Calibration, reorder aging and write-level status logic of the controller.
`default_nettype none
module ddc_core
    import ddc_pkg::*;
#(
    parameter int PERIOD_CYC = PERIOD_DEF
)
(
    // Clock and reset.
    input  wire logic                 REF_CLK,
    input  wire logic                 RESETN,
    // Reorder aging.
    input  wire logic [3:0]           REORDER_GUARD_WR_DATA,
    input  wire logic                 REORDER_GUARD_WR,
    input  wire logic                 TXN_MAX_SCORE,
    input  wire logic                 TXN_SERVED,
    output logic [3:0]                REORDER_GUARD_COUNT,
    output logic                      TXN_TOP_PRIORITY,
    // ZQ calibration.
    input  wire logic                 ZQ_AUTO_DISABLE,
    input  wire logic                 ZQ_SW_REQ,
    input  wire logic                 ZQ_SW_LONG,
    input  wire logic [1:0]           ZQ_SW_CS,
    input  wire logic                 DUAL_CS,
    output ddc_pkg::ddc_zq_cmd_t      ZQ_CMD,
    output logic                      DATA_HOLD,
    // Power-up and memory clock enable.
    input  wire logic                 POWER_GOOD,
    input  wire logic                 CKE_REQ,
    output logic                      DRAM_CLOCK_ENABLE_OUT,
    // Write leveling.
    input  wire logic                 WL_START,
    input  wire logic                 WL_LANE_DONE,
    input  wire logic [1:0]           WL_LANE_IDX,
    input  wire logic [7:0]           WL_LANE_DELAY,
    input  wire logic                 WL_LANE_ERR,
    input  wire logic [LANES-1:0]     WL_LANE_USED,
    output ddc_pkg::ddc_wl_stat_t     WL_STATUS
);
    import ddc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and power-good synchroniser.
    logic [1:0] rst_sync_r;
    logic       rst_n;
    logic [2:0] pg_sync_r;
    logic       pg_stable_r;
    logic       pg_stable_nxt;

    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    always_comb
    begin
        pg_stable_nxt = pg_stable_r;
        if (pg_sync_r[2] == pg_sync_r[1])
            pg_stable_nxt = pg_sync_r[1];
    end

    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pg_sync_r   <= 3'h0;
            pg_stable_r <= 1'b0;
        end
        else
        begin
            pg_sync_r   <= {pg_sync_r[1:0], POWER_GOOD};
            pg_stable_r <= pg_stable_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock enable output: registered, held low until power is good.
    logic cke_r;
    logic cke_nxt;

    always_comb
    begin
        cke_nxt = pg_stable_r & CKE_REQ;
    end

    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
            cke_r <= 1'b0;
        else
            cke_r <= cke_nxt;
    end
    assign DRAM_CLOCK_ENABLE_OUT = cke_r;

    ////////////////////////////////////////////////////////////////////////
    // Reorder guard count and aging.
    logic [3:0] guard_r;
    logic [3:0] guard_nxt;
    logic [3:0] age_r;
    logic [3:0] age_nxt;

    always_comb
    begin
        guard_nxt = guard_r;
        if (REORDER_GUARD_WR)
            guard_nxt = REORDER_GUARD_WR_DATA;
        age_nxt = age_r;
        if (TXN_SERVED || !TXN_MAX_SCORE)
            age_nxt = 4'h0;
        else if (age_r != AGE_MAX)
            age_nxt = age_r + 4'h1;
    end

    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            guard_r <= GUARD_RESET;
            age_r   <= 4'h0;
        end
        else
        begin
            guard_r <= guard_nxt;
            age_r   <= age_nxt;
        end
    end
    assign REORDER_GUARD_COUNT = guard_r;
    assign TXN_TOP_PRIORITY = TXN_MAX_SCORE && (age_r == AGE_MAX);

    ////////////////////////////////////////////////////////////////////////
    // ZQ calibration sequencer, one chip select at a time.
    ddc_zq_state_t zq_st_r;
    ddc_zq_state_t zq_st_nxt;
    logic [31:0]   per_r;
    logic [31:0]   per_nxt;
    logic [15:0]   wait_r;
    logic [15:0]   wait_nxt;
    logic          long_r;
    logic          long_nxt;
    logic [1:0]    mask_r;
    logic [1:0]    mask_nxt;
    ddc_zq_cmd_t   cmd_r;
    ddc_zq_cmd_t   cmd_nxt;

    function automatic logic [15:0] zq_len(input logic lng);
        zq_len = lng ? 16'(ZQCL_CYC) : 16'(ZQCS_CYC);
    endfunction

    always_comb
    begin
        zq_st_nxt = zq_st_r;
        per_nxt   = per_r;
        wait_nxt  = wait_r;
        long_nxt  = long_r;
        mask_nxt  = mask_r;
        cmd_nxt   = '0;
        if (!ZQ_AUTO_DISABLE && per_r != 32'h0)
            per_nxt = per_r - ONE32;
        case (zq_st_r)
            ZQ_IDLE:
            begin
                if (ZQ_SW_REQ)
                begin
                    long_nxt  = ZQ_SW_LONG;
                    mask_nxt  = ZQ_SW_CS;
                    zq_st_nxt = ZQ_CMD0;
                end
                else if (!ZQ_AUTO_DISABLE && per_r == 32'h0)
                begin
                    long_nxt  = 1'b0;
                    mask_nxt  = {DUAL_CS, 1'b1};
                    per_nxt   = 32'(PERIOD_CYC);
                    zq_st_nxt = ZQ_CMD0;
                end
            end
            ZQ_CMD0:
            begin
                if (mask_r[0])
                begin
                    cmd_nxt   = '{valid: 1'b1, long_cal: long_r,
                                  cs_sel: 2'h1};
                    wait_nxt  = zq_len(long_r);
                    zq_st_nxt = ZQ_WAIT0;
                end
                else
                    zq_st_nxt = ZQ_CMD1;
            end
            ZQ_WAIT0:
            begin
                wait_nxt = wait_r - 16'h1;
                if (wait_r <= 16'h1)
                    zq_st_nxt = ZQ_CMD1;
            end
            ZQ_CMD1:
            begin
                if (mask_r[1])
                begin
                    cmd_nxt   = '{valid: 1'b1, long_cal: long_r,
                                  cs_sel: 2'h2};
                    wait_nxt  = zq_len(long_r);
                    zq_st_nxt = ZQ_WAIT1;
                end
                else
                    zq_st_nxt = ZQ_IDLE;
            end
            ZQ_WAIT1:
            begin
                wait_nxt = wait_r - 16'h1;
                if (wait_r <= 16'h1)
                    zq_st_nxt = ZQ_IDLE;
            end
            default:
                zq_st_nxt = ZQ_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zq_st_r <= ZQ_IDLE;
            per_r   <= 32'h0;
            wait_r  <= 16'h0;
            long_r  <= 1'b0;
            mask_r  <= 2'h0;
            cmd_r   <= '0;
        end
        else
        begin
            zq_st_r <= zq_st_nxt;
            per_r   <= per_nxt;
            wait_r  <= wait_nxt;
            long_r  <= long_nxt;
            mask_r  <= mask_nxt;
            cmd_r   <= cmd_nxt;
        end
    end
    assign ZQ_CMD = cmd_r;
    assign DATA_HOLD = (zq_st_r != ZQ_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Write-leveling lane status.
    ddc_wl_stat_t wl_r;
    ddc_wl_stat_t wl_nxt;

    always_comb
    begin
        wl_nxt = wl_r;
        if (WL_START)
            wl_nxt = '0;
        else if (WL_LANE_DONE)
        begin
            if (WL_LANE_ERR || WL_LANE_DELAY == LANE_ZERO)
                wl_nxt.err[WL_LANE_IDX] = WL_LANE_USED[WL_LANE_IDX];
            wl_nxt.result[WL_LANE_IDX*8 +: 8] =
                WL_LANE_ERR ? LANE_ZERO : WL_LANE_DELAY;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
            wl_r <= '0;
        else
            wl_r <= wl_nxt;
    end
    assign WL_STATUS = wl_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_zq_cmd;
        cmd_r.valid;
    endsequence

    a_guard_reset: assert property (@(posedge REF_CLK)
        $rose(rst_n) |-> guard_r == GUARD_RESET)
        else $error("Guard count not zero after reset.");
    a_age_promote: assert property (@(posedge REF_CLK)
        disable iff (!rst_n) TXN_MAX_SCORE && age_r == AGE_MAX
        |-> TXN_TOP_PRIORITY)
        else $error("Aged transaction not promoted.");
    a_zq_serial: assert property (@(posedge REF_CLK)
        disable iff (!rst_n) s_zq_cmd |-> cmd_r.cs_sel != 2'h3)
        else $error("ZQ sent to both chip selects.");
    a_zq_gap: assert property (@(posedge REF_CLK)
        disable iff (!rst_n) s_zq_cmd |=> !cmd_r.valid [*8])
        else $error("ZQ commands not spaced.");
    a_zq_hold: assert property (@(posedge REF_CLK)
        disable iff (!rst_n) s_zq_cmd |-> DATA_HOLD ##1 DATA_HOLD)
        else $error("Data not held during ZQ.");
    a_zq_auto_off: assert property (@(posedge REF_CLK)
        disable iff (!rst_n) ZQ_AUTO_DISABLE && !ZQ_SW_REQ
        && zq_st_r == ZQ_IDLE |=> zq_st_r == ZQ_IDLE)
        else $error("Automatic ZQ while disabled.");
    a_cke_low: assert property (@(posedge REF_CLK)
        disable iff (!rst_n) !pg_stable_r |=> !cke_r)
        else $error("CKE high before power good.");
    a_wl_sticky: assert property (@(posedge REF_CLK)
        disable iff (!rst_n) |wl_r.err && !WL_START |=> |wl_r.err)
        else $error("Leveling error flag cleared itself.");
    a_wl_clear: assert property (@(posedge REF_CLK)
        disable iff (!rst_n) WL_START |=> wl_r == '0)
        else $error("Leveling status not cleared at start.");
    a_wl_result: assert property (@(posedge REF_CLK)
        disable iff (!rst_n) WL_LANE_DONE && !WL_START && !WL_LANE_ERR
        && WL_LANE_DELAY != LANE_ZERO
        |=> wl_r.result[$past(WL_LANE_IDX)*8 +: 8] != LANE_ZERO)
        else $error("Good lane result stored as zero.");
endmodule
`default_nettype wire

// *** test/ddc_mem_model.sv ***
// Behavioural model of the memory dies that share one calibration resistor.
`default_nettype none
module ddc_mem_model
    import ddc_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Controller pins seen by the dies.
    input  wire ddc_pkg::ddc_zq_cmd_t zq_cmd,
    input  wire logic                 cke,
    input  wire logic                 power_good,
    // Observations for the bench.
    output logic [7:0]                zq_cnt,
    output logic [31:0]               last_cs0,
    output logic [31:0]               last_cs1,
    output logic                      zq_clash,
    output logic                      cke_early
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] cyc;
    int          busy;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cyc = 0;
            busy = 0;
            zq_cnt <= 8'h00;
            last_cs0 <= 32'h0;
            last_cs1 <= 32'h0;
            zq_clash <= 1'b0;
            cke_early <= 1'b0;
        end
        else
        begin
            cyc = cyc + 1;
            if (busy > 0)
                busy = busy - 1;
            // A die calibrating blocks the shared resistor.
            if (zq_cmd.valid === 1'b1)
            begin
                if (busy > 0 || zq_cmd.cs_sel === 2'h3)
                    zq_clash <= 1'b1;
                busy = zq_cmd.long_cal ? ZQCL_CYC : ZQCS_CYC;
                zq_cnt <= zq_cnt + 8'h01;
                if (zq_cmd.cs_sel[0])
                    last_cs0 <= cyc;
                if (zq_cmd.cs_sel[1])
                    last_cs1 <= cyc;
            end
            // Clock enable must stay low until power is good.
            if (cke !== 1'b0 && power_good !== 1'b1)
                cke_early <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** test/ddc_core_test.sv ***
// Self-checking bench for the calibration and ordering core.
`default_nettype none
module ddc_core_test;
    import ddc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic         REF_CLK = 1'b0;
    logic         RESETN = 1'b0;
    logic [3:0]   REORDER_GUARD_WR_DATA = 4'h0;
    logic         REORDER_GUARD_WR = 1'b0;
    logic         TXN_MAX_SCORE = 1'b0;
    logic         TXN_SERVED = 1'b0;
    logic         ZQ_AUTO_DISABLE = 1'b1;
    logic         ZQ_SW_REQ = 1'b0;
    logic         ZQ_SW_LONG = 1'b0;
    logic [1:0]   ZQ_SW_CS = 2'h0;
    logic         POWER_GOOD = 1'b0;
    logic         WL_START = 1'b0;
    logic         WL_LANE_DONE = 1'b0;
    logic [1:0]   WL_LANE_IDX = 2'h0;
    logic [7:0]   WL_LANE_DELAY = 8'h00;
    logic         WL_LANE_ERR = 1'b0;
    logic [3:0]   REORDER_GUARD_COUNT;
    logic         TXN_TOP_PRIORITY;
    ddc_zq_cmd_t  ZQ_CMD;
    logic         DATA_HOLD;
    logic         DRAM_CLOCK_ENABLE_OUT;
    ddc_wl_stat_t WL_STATUS;
    logic [7:0]   zq_cnt;
    logic [31:0]  last_cs0;
    logic [31:0]  last_cs1;
    logic         zq_clash;
    logic         cke_early;
    int           cyc = 0;
    int           failures = 0;
    int           checks_done = 0;
    ddc_core #(.PERIOD_CYC(50)) dut_u (.REF_CLK(REF_CLK), .RESETN(RESETN),
        .REORDER_GUARD_WR_DATA(REORDER_GUARD_WR_DATA),
        .REORDER_GUARD_WR(REORDER_GUARD_WR), .TXN_MAX_SCORE(TXN_MAX_SCORE),
        .TXN_SERVED(TXN_SERVED), .REORDER_GUARD_COUNT(REORDER_GUARD_COUNT),
        .TXN_TOP_PRIORITY(TXN_TOP_PRIORITY),
        .ZQ_AUTO_DISABLE(ZQ_AUTO_DISABLE), .ZQ_SW_REQ(ZQ_SW_REQ),
        .ZQ_SW_LONG(ZQ_SW_LONG), .ZQ_SW_CS(ZQ_SW_CS), .DUAL_CS(1'b1),
        .ZQ_CMD(ZQ_CMD), .DATA_HOLD(DATA_HOLD), .POWER_GOOD(POWER_GOOD),
        .CKE_REQ(1'b1), .DRAM_CLOCK_ENABLE_OUT(DRAM_CLOCK_ENABLE_OUT),
        .WL_START(WL_START), .WL_LANE_DONE(WL_LANE_DONE),
        .WL_LANE_IDX(WL_LANE_IDX), .WL_LANE_DELAY(WL_LANE_DELAY),
        .WL_LANE_ERR(WL_LANE_ERR), .WL_LANE_USED(4'h7),
        .WL_STATUS(WL_STATUS));
    ddc_mem_model mem_u (.clk(REF_CLK), .rst_n(RESETN), .zq_cmd(ZQ_CMD),
        .cke(DRAM_CLOCK_ENABLE_OUT), .power_good(POWER_GOOD),
        .zq_cnt(zq_cnt), .last_cs0(last_cs0), .last_cs1(last_cs1),
        .zq_clash(zq_clash), .cke_early(cke_early));
    always #20 REF_CLK = ~REF_CLK;
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (failures == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge REF_CLK)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_powerup();
        tick(10);
        @(negedge REF_CLK);
        chk(DRAM_CLOCK_ENABLE_OUT, 1'b0, "cke during power-up");
        chk(REORDER_GUARD_COUNT, 4'h0, "guard reset value");
        chk(WL_STATUS, '0, "level status reset");
        @(posedge REF_CLK);
        POWER_GOOD <= 1'b1;
        tick(12);
        @(negedge REF_CLK);
        chk(DRAM_CLOCK_ENABLE_OUT, 1'b1, "cke after power good");
        chk(cke_early, 1'b0, "cke glitch");
    endtask
    task automatic age_run(input logic [3:0] g, output int n);
        @(posedge REF_CLK);
        REORDER_GUARD_WR_DATA <= g;
        REORDER_GUARD_WR <= 1'b1;
        TXN_SERVED <= 1'b1;
        @(posedge REF_CLK);
        REORDER_GUARD_WR <= 1'b0;
        TXN_SERVED <= 1'b0;
        n = 0;
        @(negedge REF_CLK);
        while (TXN_TOP_PRIORITY !== 1'b1 && n < 40)
        begin
            n++;
            @(negedge REF_CLK);
        end
        chk(REORDER_GUARD_COUNT, g, "guard stored");
    endtask
    task automatic t_aging();
        int n0;
        int n1;
        @(posedge REF_CLK);
        TXN_MAX_SCORE <= 1'b1;
        age_run(4'h0, n0);
        age_run(4'hF, n1);
        chk(n1, n0, "promotion ignores guard");
        chk(n0 >= 13 && n0 <= 16, 1'b1, "promotion at age 15");
        @(posedge REF_CLK);
        TXN_MAX_SCORE <= 1'b0;
        @(negedge REF_CLK);
        chk(TXN_TOP_PRIORITY, 1'b0, "no promotion without score");
    endtask
    task automatic t_zq_sw();
        logic [7:0] b;
        int k;
        b = zq_cnt;
        @(posedge REF_CLK);
        ZQ_SW_LONG <= 1'b1;
        ZQ_SW_CS <= 2'h3;
        ZQ_SW_REQ <= 1'b1;
        @(posedge REF_CLK);
        ZQ_SW_REQ <= 1'b0;
        tick(5);
        ZQ_SW_REQ <= 1'b1;
        @(posedge REF_CLK);
        ZQ_SW_REQ <= 1'b0;
        k = 0;
        while (zq_cnt !== b + 8'h02 && k < 100)
        begin
            k++;
            @(negedge REF_CLK);
        end
        chk(last_cs1 - last_cs0, ZQCL_CYC + 1, "die stagger");
        repeat (ZQCL_CYC - 2)
        begin
            chk(DATA_HOLD, 1'b1, "hold during calibration");
            @(negedge REF_CLK);
        end
        tick(6);
        @(negedge REF_CLK);
        chk(DATA_HOLD, 1'b0, "hold released");
        chk(zq_cnt, b + 8'h02, "busy request refused");
        chk(zq_clash, 1'b0, "resistor clash");
    endtask
    task automatic t_zq_auto();
        logic [7:0] b;
        b = zq_cnt;
        @(posedge REF_CLK);
        ZQ_AUTO_DISABLE <= 1'b0;
        tick(130);
        ZQ_AUTO_DISABLE <= 1'b1;
        tick(60);
        @(negedge REF_CLK);
        chk(zq_cnt - b >= 8'h04, 1'b1, "auto calibration runs");
        chk(last_cs1 - last_cs0, ZQCS_CYC + 1, "auto stagger");
        b = zq_cnt;
        tick(130);
        @(negedge REF_CLK);
        chk(zq_cnt, b, "auto calibration off");
        chk(zq_clash, 1'b0, "auto clash");
    endtask
    task automatic lane(input logic [1:0] i, input logic [7:0] d,
                        input logic e);
        @(posedge REF_CLK);
        WL_LANE_IDX <= i;
        WL_LANE_DELAY <= d;
        WL_LANE_ERR <= e;
        WL_LANE_DONE <= 1'b1;
        @(posedge REF_CLK);
        WL_LANE_DONE <= 1'b0;
    endtask
    task automatic wl_go();
        @(posedge REF_CLK);
        WL_START <= 1'b1;
        @(posedge REF_CLK);
        WL_START <= 1'b0;
    endtask
    task automatic t_wl();
        wl_go();
        lane(2'h0, 8'h33, 1'b1);
        lane(2'h1, 8'h5A, 1'b0);
        lane(2'h2, 8'h00, 1'b0);
        lane(2'h3, 8'h00, 1'b0);
        tick(30);
        @(negedge REF_CLK);
        chk(WL_STATUS.err[2:0], 3'h5, "lane errors held");
        chk(WL_STATUS.err[3], 1'b0, "unused lane no error");
        chk(WL_STATUS.result[15:8], 8'h5A, "lane result");
        chk(WL_STATUS.result[23:16], 8'h00, "zero lane result");
        wl_go();
        @(negedge REF_CLK);
        chk(WL_STATUS.err, 4'h0, "new run clears errors");
    endtask
    initial
    begin
        tick(6);
        RESETN <= 1'b1;
        t_powerup();
        t_aging();
        t_zq_sw();
        t_zq_auto();
        t_wl();
        summarize();
    end
endmodule
`default_nettype wire
